//--- bfs_defs.svh
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define BFS_ADDR_CMD     12'h000
`define BFS_ADDR_WREG    12'h004
`define BFS_ADDR_STATUS  12'h008
`define BFS_ADDR_PC      12'h00C
`define BFS_ADDR_IO_BASE 12'h010
`define BFS_ADDR_STAT    12'h020

// ************************************************************
// Command word fields
// ************************************************************
`define BFS_CMD_OP_LSB   0
`define BFS_CMD_OP_MSB   4
`define BFS_CMD_BIT_LSB  8
`define BFS_CMD_BIT_MSB  10
`define BFS_CMD_IO_LSB   12
`define BFS_CMD_IO_MSB   13
`define BFS_CMD_K_LSB    16
`define BFS_CMD_K_MSB    23

// ************************************************************
// Status register bit positions
// ************************************************************
`define BFS_FLAG_C       3'h0
`define BFS_FLAG_Z       3'h1
`define BFS_FLAG_N       3'h2
`define BFS_FLAG_V       3'h3
`define BFS_FLAG_S       3'h4
`define BFS_FLAG_H       3'h5
`define BFS_FLAG_T       3'h6
`define BFS_FLAG_I       3'h7

// ************************************************************
// Reset values
// ************************************************************
`define BFS_RST_CMD      32'h0000_0000
`define BFS_RST_WREG     8'h00
`define BFS_RST_STATUS   8'h00
`define BFS_RST_PC       16'h0000
`define BFS_RST_IO       8'h00
`define BFS_RST_CYCLES   2'h0

// ************************************************************
// Instruction lengths in clock cycles
// ************************************************************
`define BFS_CYCLES_ONE   2'h1
`define BFS_CYCLES_TWO   2'h2

`endif

//--- bfs_pkg.sv
package bfs_pkg;

	typedef enum logic [1:0] {
		BFS_IDLE,
		BFS_EXEC,
		BFS_FINISH
	} bfs_state_t;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_BRANCH_IRQ_OFF,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_LOGIC_SHIFT_LEFT,
		OP_LOGIC_SHIFT_RIGHT,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_ARITH_SHIFT_RIGHT,
		OP_NIBBLE_SWAP,
		OP_FLAG_SET_GENERIC,
		OP_FLAG_CLEAR_GENERIC,
		OP_BIT_TO_TRANSFER_FLAG,
		OP_TRANSFER_FLAG_TO_BIT,
		OP_CARRY_SET,
		OP_CARRY_CLEAR,
		OP_NEGATIVE_SET,
		OP_NEGATIVE_CLEAR,
		OP_ZERO_FLAG_SET,
		OP_ZERO_FLAG_CLEAR,
		OP_GLOBAL_IRQ_ON,
		OP_GLOBAL_IRQ_OFF,
		OP_SIGN_FLAG_SET,
		OP_SIGN_FLAG_CLEAR,
		OP_OVERFLOW_SET
	} bfs_op_t;

endpackage

//--- bfs_exec.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "bfs_defs.svh"

// Contract
// - Branch when interrupts off loads PC+k+1 if I is 0, flags untouched.
// - I/O bit set forces bit b of location P to 1, no flags, two cycles.
// - I/O bit clear forces bit b of location P to 0, no flags, two cycles.
// - Logical left shift inserts 0 at bit 0, updates Z C N V, one cycle.
// - Logical right shift inserts 0 at bit 7, updates Z C N V, one cycle.
// - Rotate left moves carry into bit 0, bit 7 into carry, one cycle.
// - Rotate right moves carry into bit 7, bit 0 into carry, one cycle.
// - Arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// - Nibble swap exchanges high and low halves, no flags, one cycle.
// - Generic and dedicated flag set or clear write status bit in one cycle.
// - Bit store copies register bit b into transfer flag in one cycle.
// - Bit load copies transfer flag into register bit b, no flags, one cycle.
// - Sign flag set and clear change only the sign flag, one cycle.
// - Overflow set forces only the overflow flag to 1, one cycle.
module bfs_exec
	import bfs_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	// ************************************************************
	// Helper functions
	// ************************************************************

	// Returns {carry out, result} for the shift and rotate group.
	function automatic logic [8:0] shift_calc(input bfs_op_t op, input logic [7:0] r, input logic c);
		logic [8:0] res;
		res = {c, r};
		case (op)
			OP_LOGIC_SHIFT_LEFT:   res = {r[7], r[6:0], 1'b0};
			OP_LOGIC_SHIFT_RIGHT:  res = {r[0], 1'b0, r[7:1]};
			OP_ROTATE_LEFT_CARRY:  res = {r[7], r[6:0], c};
			OP_ROTATE_RIGHT_CARRY: res = {r[0], c, r[7:1]};
			OP_ARITH_SHIFT_RIGHT:  res = {r[0], r[7], r[7:1]};
			default:               res = {c, r};
		endcase
		return res;
	endfunction

	// Returns {hit, value, index} for every flag set or clear form, not for bit store.
	function automatic logic [4:0] flag_target(input bfs_op_t op, input logic [2:0] s);
		logic [4:0] res;
		res = 5'h00;
		case (op)
			OP_FLAG_SET_GENERIC:   res = {2'b11, s};
			OP_FLAG_CLEAR_GENERIC: res = {2'b10, s};
			OP_CARRY_SET:          res = {2'b11, `BFS_FLAG_C};
			OP_CARRY_CLEAR:        res = {2'b10, `BFS_FLAG_C};
			OP_NEGATIVE_SET:       res = {2'b11, `BFS_FLAG_N};
			OP_NEGATIVE_CLEAR:     res = {2'b10, `BFS_FLAG_N};
			OP_ZERO_FLAG_SET:      res = {2'b11, `BFS_FLAG_Z};
			OP_ZERO_FLAG_CLEAR:    res = {2'b10, `BFS_FLAG_Z};
			OP_GLOBAL_IRQ_ON:      res = {2'b11, `BFS_FLAG_I};
			OP_GLOBAL_IRQ_OFF:     res = {2'b10, `BFS_FLAG_I};
			OP_SIGN_FLAG_SET:      res = {2'b11, `BFS_FLAG_S};
			OP_SIGN_FLAG_CLEAR:    res = {2'b10, `BFS_FLAG_S};
			OP_OVERFLOW_SET:       res = {2'b11, `BFS_FLAG_V};
			default:               res = 5'h00;
		endcase
		return res;
	endfunction

	// Forms that need a second cycle before they retire.
	function automatic logic two_cycle(input bfs_op_t op, input logic irq_on);
		logic res;
		res = 1'b0;
		if (op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR) begin
			res = 1'b1;
		end else if (op == OP_BRANCH_IRQ_OFF && !irq_on) begin
			res = 1'b1;
		end
		return res;
	endfunction

	// Qualifies a completed bus write to one register offset.
	function automatic logic wr_hit(input logic strobe, input logic [11:0] addr, input logic [11:0] target);
		return strobe && (addr == target);
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	bfs_state_t  state_q;
	logic [31:0] cmd_q;
	logic [7:0]  wreg_q;
	logic [7:0]  status_q;
	logic [15:0] pc_q;
	logic [7:0]  io_q [4];
	logic [1:0]  cycles_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	bfs_op_t     op;
	logic [2:0]  bit_sel;
	logic [1:0]  io_sel;
	logic [7:0]  k_off;
	logic        busy;
	logic        ack;
	logic        wr_ack;
	logic        stall;
	logic        mapped;
	logic        io_hit;
	logic [31:0] rdata;
	logic [8:0]  sh;
	logic [4:0]  ft;
	logic [7:0]  wreg_d;
	logic [7:0]  status_d;
	logic        wr_cmd;
	logic        wr_wreg;
	logic        wr_status;
	logic        wr_pc;
	logic        acc_new;
	logic        long_op;
	logic        io_set;
	logic        io_clr;
	logic [15:0] k_ext;
	logic [15:0] pc_d;

	assign op      = bfs_op_t'(cmd_q[`BFS_CMD_OP_MSB:`BFS_CMD_OP_LSB]);
	assign bit_sel = cmd_q[`BFS_CMD_BIT_MSB:`BFS_CMD_BIT_LSB];
	assign io_sel  = cmd_q[`BFS_CMD_IO_MSB:`BFS_CMD_IO_LSB];
	assign k_off   = cmd_q[`BFS_CMD_K_MSB:`BFS_CMD_K_LSB];
	assign busy    = (state_q != BFS_IDLE);
	assign ack     = psel && penable && pready_q;
	assign wr_ack  = ack && pwrite;
	assign acc_new = psel && penable && !pready_q;
	assign io_hit  = (paddr[11:4] == 8'(`BFS_ADDR_IO_BASE >> 4));
	assign long_op = two_cycle(op, status_q[`BFS_FLAG_I]);
	assign io_set  = (state_q == BFS_FINISH) && (op == OP_IO_BIT_SET);
	assign io_clr  = (state_q == BFS_FINISH) && (op == OP_IO_BIT_CLEAR);
	assign k_ext   = {{8{k_off[7]}}, k_off};

	// Writes wait while an instruction runs, so bus and execution never touch state together.
	assign stall   = pwrite && busy;

	// ************************************************************
	// Register write decode
	// ************************************************************
	assign wr_cmd    = wr_hit(wr_ack, paddr, `BFS_ADDR_CMD);
	assign wr_wreg   = wr_hit(wr_ack, paddr, `BFS_ADDR_WREG);
	assign wr_status = wr_hit(wr_ack, paddr, `BFS_ADDR_STATUS);
	assign wr_pc     = wr_hit(wr_ack, paddr, `BFS_ADDR_PC);

	// ************************************************************
	// APB slave
	// ************************************************************
	always_comb begin
		mapped = 1'b1;
		rdata  = 32'h0000_0000;
		if (paddr == `BFS_ADDR_CMD) begin
			rdata = cmd_q;
		end else if (paddr == `BFS_ADDR_WREG) begin
			rdata = {24'h000000, wreg_q};
		end else if (paddr == `BFS_ADDR_STATUS) begin
			rdata = {24'h000000, status_q};
		end else if (paddr == `BFS_ADDR_PC) begin
			rdata = {16'h0000, pc_q};
		end else if (io_hit && paddr[1:0] == 2'h0) begin
			rdata = {24'h000000, io_q[paddr[3:2]]};
		end else if (paddr == `BFS_ADDR_STAT) begin
			rdata = {29'h00000000, cycles_q, busy};
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc_new && !stall;
			pslverr_q <= acc_new && !stall && !mapped;
			prdata_q  <= (acc_new && !pwrite && mapped) ? rdata : 32'h0000_0000;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= BFS_IDLE;
		end else begin
			case (state_q)
				BFS_IDLE: begin
					if (wr_cmd) begin
						state_q <= BFS_EXEC;
					end
				end
				BFS_EXEC: begin
					if (long_op) begin
						state_q <= BFS_FINISH;
					end else begin
						state_q <= BFS_IDLE;
					end
				end
				default: begin
					state_q <= BFS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_q <= `BFS_RST_CMD;
		end else if (wr_cmd) begin
			cmd_q <= pwdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cycles_q <= `BFS_RST_CYCLES;
		end else if (state_q == BFS_EXEC) begin
			cycles_q <= `BFS_CYCLES_ONE;
		end else if (state_q == BFS_FINISH) begin
			cycles_q <= `BFS_CYCLES_TWO;
		end
	end

	// ************************************************************
	// Datapath
	// ************************************************************
	always_comb begin
		sh       = shift_calc(op, wreg_q, status_q[`BFS_FLAG_C]);
		ft       = flag_target(op, bit_sel);
		wreg_d   = wreg_q;
		status_d = status_q;
		case (op)
			OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
			OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
				wreg_d                = sh[7:0];
				status_d[`BFS_FLAG_C] = sh[8];
				status_d[`BFS_FLAG_Z] = (sh[7:0] == 8'h00);
				status_d[`BFS_FLAG_N] = sh[7];
				status_d[`BFS_FLAG_V] = sh[7] ^ sh[8];
			end
			OP_NIBBLE_SWAP: begin
				wreg_d = {wreg_q[3:0], wreg_q[7:4]};
			end
			OP_BIT_TO_TRANSFER_FLAG: begin
				status_d[`BFS_FLAG_T] = wreg_q[bit_sel];
			end
			OP_TRANSFER_FLAG_TO_BIT: begin
				wreg_d[bit_sel] = status_q[`BFS_FLAG_T];
			end
			default: begin
				if (ft[4]) begin
					status_d[ft[2:0]] = ft[3];
				end
			end
		endcase
	end

	// ************************************************************
	// Working and status registers
	// ************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wreg_q <= `BFS_RST_WREG;
		end else if (state_q == BFS_EXEC) begin
			wreg_q <= wreg_d;
		end else if (wr_wreg) begin
			wreg_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			status_q <= `BFS_RST_STATUS;
		end else if (state_q == BFS_EXEC) begin
			status_q <= status_d;
		end else if (wr_status) begin
			status_q <= pwdata[7:0];
		end
	end

	// ************************************************************
	// Program counter
	// ************************************************************

	// Every instruction is one word, so untaken flow advances by one.
	always_comb begin
		pc_d = pc_q;
		if (state_q == BFS_FINISH && op == OP_BRANCH_IRQ_OFF) begin
			pc_d = pc_q + k_ext + 16'h0001;
		end else if (state_q == BFS_FINISH) begin
			pc_d = pc_q + 16'h0001;
		end else if (state_q == BFS_EXEC && !long_op) begin
			pc_d = pc_q + 16'h0001;
		end else if (wr_pc) begin
			pc_d = pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc_q <= `BFS_RST_PC;
		end else begin
			pc_q <= pc_d;
		end
	end

	// ************************************************************
	// I/O locations
	// ************************************************************

	// Read-modify-write of the I/O byte lands in the second cycle.
	generate
		for (genvar i = 0; i < 4; i++) begin : g_io
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					io_q[i] <= `BFS_RST_IO;
				end else if (io_set && io_sel == 2'(i)) begin
					io_q[i][bit_sel] <= 1'b1;
				end else if (io_clr && io_sel == 2'(i)) begin
					io_q[i][bit_sel] <= 1'b0;
				end else if (wr_ack && io_hit && paddr[3:0] == {2'(i), 2'b00}) begin
					io_q[i] <= pwdata[7:0];
				end
			end
		end
	endgenerate

endmodule

//--- bfs_exec_sva.sv
`timescale 1ns/1ps
module bfs_exec_sva (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire acc = psel & penable;
	a_ready_in_access: assert property (pready |-> acc) else $error("pready outside access");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	a_read_no_wait: assert property ($rose(acc) && !pwrite |=> pready) else $error("read waited");
	a_unmapped_err: assert property ($rose(acc) && !pwrite && paddr > 12'h023 |=> pslverr)
		else $error("unmapped read not refused");
	a_mapped_no_err: assert property ($rose(acc) && paddr <= 12'h020 && paddr[1:0] == 2'h0
		|-> ##[1:5] pready && !pslverr) else $error("mapped access refused");
	a_write_bounded: assert property ($rose(acc) && pwrite |-> ##[1:5] pready) else $error("write stalled too long");
	a_stat_narrow: assert property (pready && !pwrite && paddr == 12'h020 |-> prdata[31:3] == 29'h0)
		else $error("status word too wide");
endmodule
bind bfs_exec bfs_exec_sva bfs_exec_sva_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

//--- tb.sv
`timescale 1ns/1ps
module tb;
	import bfs_pkg::*;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [32:0] exp_q[$];
	int          failures, num_checks;
	logic [7:0]  w, s, k, r;
	logic [7:0]  io[4];
	logic [15:0] pc;
	logic [2:0]  b;
	logic [1:0]  p, cyc;
	logic [2:0]  fl[5] = '{0, 2, 1, 7, 4};
	bfs_exec bfs_exec_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		num_checks++;
		if (seen !== want) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	always @(posedge clk) if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
		check({pslverr, prdata}, exp_q.pop_front());
	end
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic e);
		exp_q.push_back({e, v});
		xfer(1'b0, a, 32'h0);
	endtask
	// ****************************************
	// Reference behaviour of one instruction
	// ****************************************
	task model(input int op);
		cyc = 2'h1;
		pc = pc + 16'h1;
		case (op)
			1: if (!s[7]) {cyc, pc} = {2'h2, pc + {{8{k[7]}}, k}};
			2, 3: {cyc, io[p][b]} = {2'h2, op == 2};
			4: {s[0], r} = {w, 1'b0};
			5: {r, s[0]} = {1'b0, w};
			6: {s[0], r} = {w, s[0]};
			7: {r, s[0]} = {s[0], w};
			8: {r, s[0]} = {w[7], w};
			9: w = {w[3:0], w[7:4]};
			10, 11: s[b] = (op == 10);
			12: s[6] = w[b];
			13: w[b] = s[6];
			24: s[3] = 1'b1;
			default: if (op >= 14 && op <= 23) s[fl[(op - 14) / 2]] = !op[0];
		endcase
		if (op >= 4 && op <= 8) begin
			w = r;
			s[3:1] = {r[7] ^ s[0], r[7], r == 8'h0};
		end
	endtask
	task print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict;
	end
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(11345));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		xfer(1'b1, 12'h040, 32'hFF);
		for (int i = 0; i < 9; i++) rd(12'(i * 4), 32'h0, 1'b0);
		rd(12'h024, 32'h0, 1'b1);
		$display("test reset done");
		for (int t = 0; t < 3; t++) begin
			for (int op = 0; op < 32; op++) begin
				{w, s, k, pc, b, p} = 45'({$urandom, $urandom});
				s[7] = t[0];
				io[p] = 8'($urandom);
				xfer(1'b1, 12'h004, {24'h0, w});
				xfer(1'b1, 12'h008, {24'h0, s});
				xfer(1'b1, 12'h00C, {16'h0, pc});
				xfer(1'b1, {8'h01, p, 2'h0}, {24'h0, io[p]});
				xfer(1'b1, 12'h000, {8'h0, k, 2'h0, p, 1'b0, b, 3'h0, 5'(op)});
				// Status is read-only; this write stalls until idle, so later reads see settled results.
				xfer(1'b1, 12'h020, 32'h7);
				model(op);
				rd(12'h004, {24'h0, w}, 1'b0);
				rd(12'h008, {24'h0, s}, 1'b0);
				rd(12'h00C, {16'h0, pc}, 1'b0);
				rd({8'h01, p, 2'h0}, {24'h0, io[p]}, 1'b0);
				rd(12'h020, {29'h0, cyc, 1'b0}, 1'b0);
			end
			$display("test pass %0d done", t);
		end
		psel <= 1'b0;
		repeat (2) @(posedge clk);
		print_verdict;
	end
endmodule
